/* File: hdl/ccd_top.sv */
// Register access over Avalon-MM was left to the implementer.
`include "ccd_map.svh"

// Function
// R1: direct bit 0 routes pair b from divider one, 1 routes vco or ext clk; the code keeps divider one when clock-input bits are 01b.
// R2: bit 0 of each routing register disables duty correction when set.
// R3: divider two stays low for the low-count field plus one input cycles.
// R4: divider two stays high for the high-count field plus one input cycles.
// R5: bypass bit passes the divider input straight to its output.
// R6: divider two obeys chip sync unless its no-sync bit is set.
// R7: force-high drives the output high only when no-sync is also set.
// R8: force-high has no effect while the bypass bit is set.
// R9: start-high bit picks the level the output begins at after a sync.
// R10: divider two holds a four-bit phase-offset field, reset to zero.
// R11: direct bit 0 routes pair c from divider two, 1 routes vco or ext; the code keeps divider two when clock-input bits are 01b.
// R12: sync holds the divider static while asserted, restarts on release.
// R13: clock-input bit 1 picks vco or ext clk; bits 1 and 0 never both set.
// R14: after sync, first edge waits phase cycles; period is low+high+2.
module ccd_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        vco_clk_in,
    input  wire logic        ext_clk_in,
    input  wire logic        div_one_in,
    input  wire logic        sync_n,
    output logic             pair_b_output_p,
    output logic             pair_b_output_n,
    output logic             pair_c_output_p,
    output logic             pair_c_output_n,
    output logic             duty_correction_disable_b,
    output logic             duty_correction_disable_c
);
    // pin order: 3 sync_n, 2 divider one, 1 ext clk, 0 vco
    logic [3:0]          pin_meta;
    logic [3:0]          pin_sync;
    logic [3:0]          pin_prev;
    ccd_pkg::ccd_route_t div1_route;
    ccd_pkg::ccd_route_t next_div1_route;
    ccd_pkg::ccd_counts_t div2_counts;
    ccd_pkg::ccd_counts_t next_div2_counts;
    ccd_pkg::ccd_ctrl_t  div2_ctrl;
    ccd_pkg::ccd_ctrl_t  next_div2_ctrl;
    ccd_pkg::ccd_route_t div2_route;
    ccd_pkg::ccd_route_t next_div2_route;
    logic [1:0]          clk_in_sel;
    logic [1:0]          next_clk_in_sel;
    logic                soft_sync;
    logic                next_soft_sync;
    logic                next_waitrequest;
    logic [31:0]         next_readdata;
    ccd_pkg::ccd_state_t state;
    ccd_pkg::ccd_state_t next_state;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic                div_out;
    logic                next_div_out;
    logic                next_b_lvl;
    logic                next_c_lvl;
    logic                req;
    logic                wr_go;
    logic                dist_lvl;
    logic                dist_rise;
    logic                sync_hold;
    logic                div2_lvl;

    function automatic logic route_level(
        input logic       direct,
        input logic [1:0] sel,
        input logic       div_lvl,
        input logic       vco,
        input logic       ext
    );
        logic lvl;
        lvl = div_lvl;
        // 01b and the illegal 11b leave the divider route in place
        if (direct && sel == `CCD_SRC_VCO) begin
            lvl = vco;
        end else if (direct && sel == `CCD_SRC_EXT) begin
            lvl = ext;
        end
        return lvl;
    endfunction : route_level

    // three flops per pin; pin_prev only feeds the edge detect
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta <= `CCD_PINS_RESET;
            pin_sync <= `CCD_PINS_RESET;
            pin_prev <= `CCD_PINS_RESET;
        end else begin
            pin_meta <= {sync_n, div_one_in, ext_clk_in, vco_clk_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign req   = avs_read | avs_write;
    assign wr_go = avs_write & ~avs_waitrequest;

    // register file and bus slave
    always_comb begin
        next_waitrequest = ~(req & avs_waitrequest);
        next_readdata    = avs_readdata;
        next_div1_route  = div1_route;
        next_div2_counts = div2_counts;
        next_div2_ctrl   = div2_ctrl;
        next_div2_route  = div2_route;
        next_clk_in_sel  = clk_in_sel;
        next_soft_sync   = soft_sync;
        if (avs_read && avs_waitrequest) begin
            next_readdata = 32'h0000_0000;
            case (avs_address)
                `CCD_DIV1_ROUTE_IDX: next_readdata[1:0] = div1_route;
                `CCD_DIV2_COUNT_IDX: next_readdata[7:0] = div2_counts;
                `CCD_DIV2_CTRL_IDX:  next_readdata[7:0] = div2_ctrl;
                `CCD_DIV2_ROUTE_IDX: next_readdata[1:0] = div2_route;
                `CCD_CLK_IN_IDX:     next_readdata[1:0] = clk_in_sel;
                `CCD_SYSTEM_IDX:     next_readdata[0]   = soft_sync;
                `CCD_STATUS_IDX: begin
                    next_readdata[0] = div_out;
                    next_readdata[1] = (state == ccd_pkg::ST_HOLD);
                end
                default: next_readdata = 32'h0000_0000;
            endcase
        end
        if (wr_go) begin
            case (avs_address)
                `CCD_DIV1_ROUTE_IDX: next_div1_route = avs_writedata[1:0];
                `CCD_DIV2_COUNT_IDX: next_div2_counts = avs_writedata[7:0];
                `CCD_DIV2_CTRL_IDX:  next_div2_ctrl = avs_writedata[7:0];
                `CCD_DIV2_ROUTE_IDX: next_div2_route = avs_writedata[1:0];
                `CCD_CLK_IN_IDX: begin
                    // vco select with divider bypass is refused [R13]
                    if (avs_writedata[1:0] != `CCD_SRC_ILLEGAL) begin
                        next_clk_in_sel = avs_writedata[1:0];
                    end
                end
                `CCD_SYSTEM_IDX:
                    next_soft_sync = avs_writedata[`CCD_SOFT_SYNC_BIT];
                default: next_soft_sync = soft_sync;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            div1_route      <= `CCD_ROUTE_RESET;
            div2_counts     <= `CCD_BYTE_RESET;
            div2_ctrl       <= `CCD_BYTE_RESET;
            div2_route      <= `CCD_ROUTE_RESET;
            clk_in_sel      <= `CCD_ROUTE_RESET;
            soft_sync       <= 1'b0;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
            div1_route      <= next_div1_route;
            div2_counts     <= next_div2_counts;
            div2_ctrl       <= next_div2_ctrl;
            div2_route      <= next_div2_route;
            clk_in_sel      <= next_clk_in_sel;
            soft_sync       <= next_soft_sync;
        end
    end

    // divider input: vco or ext clk per clock-input bit 1 [R13]
    assign dist_lvl  = clk_in_sel[`CCD_SEL_VCO_BIT] ? pin_sync[0]
                                                     : pin_sync[1];
    assign dist_rise = dist_lvl & ~(clk_in_sel[`CCD_SEL_VCO_BIT]
                                    ? pin_prev[0] : pin_prev[1]);
    // soft sync bit is the pin inverted; no-sync masks both [R6] [R12]
    assign sync_hold = (~pin_sync[3] | soft_sync) & ~div2_ctrl.nosync;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_div_out = div_out;
        if (sync_hold) begin
            next_state   = ccd_pkg::ST_HOLD; // [R12]
            next_div_out = div2_ctrl.start_high; // [R9]
        end else begin
            unique case (state)
                ccd_pkg::ST_HOLD: begin
                    next_state = ccd_pkg::ST_PHASE;
                    next_cnt   = div2_ctrl.phase; // [R10] [R14]
                end
                ccd_pkg::ST_PHASE: begin
                    if (dist_rise && cnt == `CCD_COUNT_ZERO) begin
                        next_div_out = div2_ctrl.start_high; // [R9]
                        if (div2_ctrl.start_high) begin
                            next_state = ccd_pkg::ST_HIGH;
                            next_cnt   = div2_counts.high;
                        end else begin
                            next_state = ccd_pkg::ST_LOW;
                            next_cnt   = div2_counts.low;
                        end
                    end else if (dist_rise) begin
                        next_cnt = cnt - 4'h1; // [R14]
                    end
                end
                ccd_pkg::ST_LOW: begin
                    if (dist_rise && cnt == `CCD_COUNT_ZERO) begin
                        next_state   = ccd_pkg::ST_HIGH;
                        next_cnt     = div2_counts.high; // [R4]
                        next_div_out = 1'b1;
                    end else if (dist_rise) begin
                        next_cnt = cnt - 4'h1; // [R3]
                    end
                end
                ccd_pkg::ST_HIGH: begin
                    if (dist_rise && cnt == `CCD_COUNT_ZERO) begin
                        next_state   = ccd_pkg::ST_LOW;
                        next_cnt     = div2_counts.low; // [R3]
                        next_div_out = 1'b0;
                    end else if (dist_rise) begin
                        next_cnt = cnt - 4'h1; // [R4]
                    end
                end
            endcase
        end
    end

    // bypass wins over force; force needs no-sync [R5] [R7] [R8]
    assign div2_lvl = div2_ctrl.bypass ? dist_lvl
                    : (div2_ctrl.nosync & div2_ctrl.force_high) | div_out;

    always_comb begin
        next_b_lvl = route_level(div1_route.direct, clk_in_sel,
                                 pin_sync[2], pin_sync[0],
                                 pin_sync[1]); // [R1]
        next_c_lvl = route_level(div2_route.direct, clk_in_sel,
                                 div2_lvl, pin_sync[0],
                                 pin_sync[1]); // [R11]
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state                     <= ccd_pkg::ST_LOW;
            cnt                       <= `CCD_COUNT_ZERO;
            div_out                   <= 1'b0;
            pair_b_output_p           <= 1'b0;
            pair_b_output_n           <= 1'b1;
            pair_c_output_p           <= 1'b0;
            pair_c_output_n           <= 1'b1;
            duty_correction_disable_b <= 1'b0;
            duty_correction_disable_c <= 1'b0;
        end else begin
            state                     <= next_state;
            cnt                       <= next_cnt;
            div_out                   <= next_div_out;
            pair_b_output_p           <= next_b_lvl;
            pair_b_output_n           <= ~next_b_lvl;
            pair_c_output_p           <= next_c_lvl;
            pair_c_output_n           <= ~next_c_lvl;
            duty_correction_disable_b <= div1_route.dcc_off; // [R2]
            duty_correction_disable_c <= div2_route.dcc_off; // [R2]
        end
    end

    default clocking ccd_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    route_b_direct_a: assert property ( // [R1]
        div1_route.direct && clk_in_sel == `CCD_SRC_VCO
        |=> pair_b_output_p == $past(pin_sync[0]))
        else $error("pair b not taking vco");
    route_b_div_a: assert property ( // [R1]
        !div1_route.direct |=> pair_b_output_p == $past(pin_sync[2])
                            && pair_b_output_n != pair_b_output_p)
        else $error("pair b not taking divider one");
    dcc_flag_a: assert property ( // [R2]
        $changed(div2_route.dcc_off)
        |=> duty_correction_disable_c == $past(div2_route.dcc_off))
        else $error("duty correction flag stale");
    low_reload_a: assert property ( // [R3]
        !sync_hold && state == ccd_pkg::ST_HIGH && dist_rise
        && cnt == `CCD_COUNT_ZERO
        |=> state == ccd_pkg::ST_LOW && !div_out
            && cnt == $past(div2_counts.low))
        else $error("low phase not loaded");
    high_reload_a: assert property ( // [R4]
        !sync_hold && state == ccd_pkg::ST_LOW && dist_rise
        && cnt == `CCD_COUNT_ZERO
        |=> state == ccd_pkg::ST_HIGH && div_out
            && cnt == $past(div2_counts.high))
        else $error("high phase not loaded");
    bypass_pass_a: assert property ( // [R5]
        div2_ctrl.bypass && !div2_route.direct
        |=> pair_c_output_p == $past(dist_lvl))
        else $error("bypass not passing input");
    sync_hold_a: assert property ( // [R6]
        (~pin_sync[3] | soft_sync) && !div2_ctrl.nosync
        |=> state == ccd_pkg::ST_HOLD)
        else $error("sync not holding divider");
    force_high_a: assert property ( // [R7]
        div2_ctrl.nosync && div2_ctrl.force_high && !div2_ctrl.bypass
        && !div2_route.direct |=> pair_c_output_p)
        else $error("force high not applied");
    start_level_a: assert property ( // [R9]
        sync_hold |=> div_out == $past(div2_ctrl.start_high))
        else $error("static level not start level");
    phase_load_a: assert property ( // [R14]
        state == ccd_pkg::ST_HOLD && !sync_hold
        |=> state == ccd_pkg::ST_PHASE && cnt == $past(div2_ctrl.phase))
        else $error("phase offset not loaded");
    route_c_ext_a: assert property ( // [R11]
        div2_route.direct && clk_in_sel == `CCD_SRC_EXT
        |=> pair_c_output_p == $past(pin_sync[1]))
        else $error("pair c not taking ext clk");
    src_guard_a: assert property ( // [R13]
        clk_in_sel != `CCD_SRC_ILLEGAL)
        else $error("vco with divider bypass");

    cover property (state == ccd_pkg::ST_HOLD ##1 state == ccd_pkg::ST_PHASE);
    cover property (state == ccd_pkg::ST_LOW
                    ##[1:40] state == ccd_pkg::ST_HIGH);
    cover property (wr_go && avs_address == `CCD_DIV2_CTRL_IDX);
endmodule : ccd_top

/* File: include/ccd_map.svh */
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH
`define CCD_DIV1_ROUTE_IDX  10'h195
`define CCD_DIV2_COUNT_IDX  10'h196
`define CCD_DIV2_CTRL_IDX   10'h197
`define CCD_DIV2_ROUTE_IDX  10'h198
`define CCD_CLK_IN_IDX      10'h1e1
`define CCD_SYSTEM_IDX      10'h230
`define CCD_STATUS_IDX      10'h3f0
`define CCD_DIRECT_BIT      1
`define CCD_DCC_OFF_BIT     0
`define CCD_SEL_VCO_BIT     1
`define CCD_SOFT_SYNC_BIT   0
`define CCD_SRC_VCO         2'h2
`define CCD_SRC_EXT         2'h0
`define CCD_SRC_ILLEGAL     2'h3
`define CCD_ROUTE_RESET     2'h0
`define CCD_BYTE_RESET      8'h00
`define CCD_COUNT_ZERO      4'h0
`define CCD_PINS_RESET      4'h8
`endif

/* File: include/ccd_pkg.sv */
package ccd_pkg;
    typedef enum logic [3:0] {
        ST_HOLD  = 4'h1,
        ST_PHASE = 4'h2,
        ST_LOW   = 4'h4,
        ST_HIGH  = 4'h8
    } ccd_state_t;

    typedef struct packed {
        logic [3:0] low;
        logic [3:0] high;
    } ccd_counts_t;

    typedef struct packed {
        logic       bypass;
        logic       nosync;
        logic       force_high;
        logic       start_high;
        logic [3:0] phase;
    } ccd_ctrl_t;

    typedef struct packed {
        logic direct;
        logic dcc_off;
    } ccd_route_t;
endpackage : ccd_pkg

/* File: tb/ccd_load_model.sv */
// downstream load on one output pair: measures level run lengths in clk
// cycles; a glitch-free divider shows fixed runs once settled
module ccd_load_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin_p,
    input  wire logic pin_n,
    output int        hi_len,
    output int        lo_len,
    output int        still,
    output int        n_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    int   run;
    logic last;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {hi_len, lo_len, still, n_bad, run} <= '0;
            last <= 1'b0;
        end else begin
            if (pin_p !== last) begin
                if (last) hi_len <= run;
                else lo_len <= run;
                run   <= 1;
                still <= 0;
            end else begin
                run   <= run + 1;
                still <= still + 1;
            end
            last <= pin_p;
            // a pair whose legs agree would load the line unevenly
            if (pin_n !== ~pin_p) n_bad <= n_bad + 1;
        end
    end
endmodule : ccd_load_model

/* File: tb/tb_channel_clock_divider.sv */
module tb_channel_clock_divider;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        vco, ext, div1, sync_n, b_p, b_n, c_p, c_n, dcc_b, dcc_c;
    int          miscompares, compares, cyc, cnt;
    int          hb, lb, sb, nbb, hc, lc, sc, nbc;
    logic [3:0]  lo, hi;
    ccd_top uut (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .vco_clk_in(vco),
        .ext_clk_in(ext), .div_one_in(div1), .sync_n(sync_n),
        .pair_b_output_p(b_p), .pair_b_output_n(b_n),
        .pair_c_output_p(c_p), .pair_c_output_n(c_n),
        .duty_correction_disable_b(dcc_b),
        .duty_correction_disable_c(dcc_c));
    ccd_load_model mb (.clk(clk), .reset(reset), .pin_p(b_p), .pin_n(b_n),
        .hi_len(hb), .lo_len(lb), .still(sb), .n_bad(nbb));
    ccd_load_model mc (.clk(clk), .reset(reset), .pin_p(c_p), .pin_n(c_n),
        .hi_len(hc), .lo_len(lc), .still(sc), .n_bad(nbc));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // sources no faster than 4 clk periods so the pin synchronisers keep edges
    always @(posedge clk) begin
        cnt  <= cnt + 1;
        ext  <= (cnt % 4) < 2;
        vco  <= (cnt % 6) < 3;
        div1 <= (cnt % 8) < 4;
        cyc  <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic [9:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, {24'h00_0000, d});
    endtask : wr
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : pause
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    task automatic set_sync(input logic v);
        @(posedge clk);
        sync_n <= v;
    endtask : set_sync
    initial begin
        {avs_read, avs_write, vco, ext, div1} = '0;
        {avs_address, avs_writedata, miscompares, compares, cyc, cnt} = '0;
        sync_n = 1'b1;
        reset  = 1'b1;
        void'($urandom(88));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus(10'h195 + 10'(i), 1'b0, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        bus(10'h100, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        done("reset");
        wr(10'h195, 8'h01);
        wr(10'h198, 8'h01);
        pause(4);
        chk({dcc_b, dcc_c}, 2'b11);
        wr(10'h195, 8'h00);
        wr(10'h198, 8'h00);
        pause(4);
        chk({dcc_b, dcc_c}, 2'b00);
        done("duty");
        for (int i = 0; i < 6; i++) begin
            lo = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom_range(15));
            hi = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom_range(15));
            wr(10'h196, {lo, hi});
            wr(10'h197, 8'($urandom_range(15)));
            pause(300);
            chk(hc, (hi + 1) * 4);
            chk(lc, (lo + 1) * 4);
            chk(hc + lc, (lo + hi + 2) * 4);
        end
        bus(10'h196, 1'b0, 32'h0000_0000);
        chk(q, {24'h00_0000, lo, hi});
        done("counts");
        wr(10'h196, 8'h00);
        wr(10'h197, 8'h80);
        pause(40);
        chk(hc, 2);
        chk(lc, 2);
        wr(10'h197, 8'he0);
        pause(40);
        chk(hc, 2);
        wr(10'h197, 8'h60);
        pause(40);
        chk({c_p, 1'(sc >= 30)}, 2'b11);
        wr(10'h197, 8'h20);
        pause(40);
        chk(hc, 4);
        done("bypass force");
        for (int s = 0; s < 2; s++) begin
            wr(10'h197, 8'(s << 4));
            set_sync(1'b0);
            pause(40);
            chk(c_p, s);
            chk(sc >= 30, 1);
            set_sync(1'b1);
            pause(60);
            chk(sc < 20, 1);
        end
        wr(10'h197, 8'h40);
        set_sync(1'b0);
        pause(60);
        chk(sc < 20, 1);
        set_sync(1'b1);
        wr(10'h197, 8'h00);
        wr(10'h230, 8'h01);
        pause(40);
        chk(sc >= 30, 1);
        bus(10'h3f0, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_0002);
        wr(10'h230, 8'h00);
        pause(60);
        chk(sc < 20, 1);
        done("sync");
        wr(10'h196, 8'h33);
        wr(10'h1e1, 8'h02);
        pause(300);
        chk(hc, 24);
        wr(10'h198, 8'h02);
        pause(60);
        chk(hc, 3);
        wr(10'h1e1, 8'h00);
        pause(60);
        chk(hc, 2);
        wr(10'h1e1, 8'h01);
        pause(300);
        chk(hc, 16);
        wr(10'h1e1, 8'h03);
        bus(10'h1e1, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        wr(10'h1e1, 8'h00);
        pause(60);
        chk(hb, 4);
        wr(10'h195, 8'h02);
        pause(60);
        chk(hb, 2);
        wr(10'h1e1, 8'h02);
        pause(60);
        chk(hb, 3);
        chk(nbb, 0);
        chk(nbc, 0);
        done("routing");
        complete_run();
    end
endmodule : tb_channel_clock_divider
